// ===== design/msra_server.sv
// modbus server local register bank with holding, input, coil and discrete views
`include "msra_params.svh"
module msra_server
   import msra_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [15:0] cfgPort,
   input wire logic restartReq,
   output logic serverOn,
   output logic [15:0] listenPort,
   input wire logic cfgWe,
   input wire logic [`MSRA_AW-1:0] cfgAddr,
   input wire logic [1:0] cfgFmt,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic [1:0] reqView,
   input wire logic reqWrite,
   input wire logic [`MSRA_AW-1:0] reqAddr,
   input wire logic [`MSRA_AW:0] reqCount,
   input wire logic [15:0] reqData,
   input wire logic wrValid,
   output logic wrReady,
   output logic rspValid,
   output logic [15:0] rspData,
   output logic rspLast,
   output logic rspExc,
   output logic [7:0] rspExcCode
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MSRA_ST_IDLE = 2'b00,
      MSRA_ST_XFER = 2'b01,
      MSRA_ST_DONE = 2'b10
   } msra_state_t;

   logic [15:0] regQ [`MSRA_NREGS];
   logic [1:0] fmtQ [`MSRA_NREGS];
   msra_state_t stateQ, stateD;
   logic [`MSRA_AW-1:0] ptrQ;
   logic [`MSRA_AW:0] leftQ;
   logic [1:0] viewQ;
   logic writeQ;
   logic [15:0] portQ;
   logic onQ;
   logic [15:0] dataQ;
   logic validQ, lastQ, excQ;
   logic [7:0] excCodeQ;
   logic [`MSRA_NREGS-1:0] isStart, isWide;
   logic [7:0] excCode;
   logic wrFire;
   logic reqDataBit;
   logic [15:0] wrValue;

   // ------------------------------------------------------------
   // value layout from the format table
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `MSRA_NREGS; gi++) begin : g_layout
         assign isWide[gi] = fmtQ[gi][1];
         // a register is a continuation if the one before is a float start, or if it and the one before are both strings
         if (gi == 0) begin : g_first
            assign isStart[gi] = 1'b1;
         end else begin : g_rest
            assign isStart[gi] = !(isStart[gi-1] && isWide[gi-1] &&
                                  fmtQ[gi-1] == MSRA_FMT_F32) &&
                                 !(isWide[gi] && fmtQ[gi] == MSRA_FMT_STR &&
                                   fmtQ[gi-1] == MSRA_FMT_STR);
            chk_float_pair: assert property (@(posedge mclk) disable iff (!reset_n)
               isStart[gi-1] && fmtQ[gi-1] == MSRA_FMT_F32 |-> !isStart[gi])
               else $error("float second word marked as start");
         end
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               regQ[gi] <= `MSRA_REG_RESET;
               fmtQ[gi] <= `MSRA_FMT_RESET;
            end else begin
               if (cfgWe && cfgAddr == (`MSRA_AW)'(gi)) begin
                  fmtQ[gi] <= cfgFmt;
               end
               if (wrFire && ptrQ == (`MSRA_AW)'(gi)) begin
                  regQ[gi] <= wrValue;
               end
            end
         end
      end
   endgenerate

   msra_check u_check (
      .view(reqView),
      .isWrite(reqWrite),
      .addr(reqAddr),
      .count(reqCount),
      .isStart(isStart),
      .isWide(isWide),
      .excCode(excCode)
   );

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   wire logic idle = (stateQ == MSRA_ST_IDLE);
   wire logic reqFire = reqValid && idle && onQ;
   wire logic reqBad = excCode != `MSRA_EXC_NONE;
   wire logic inXfer = (stateQ == MSRA_ST_XFER);
   assign wrFire = inXfer && writeQ && wrValid;
   wire logic rdStep = inXfer && !writeQ;
   wire logic stepOk = wrFire || rdStep;
   wire logic lastStep = (leftQ == (`MSRA_AW+1)'(1));
   // coil write stores one for any nonzero value, the client sends zero or one
   assign reqDataBit = reqData != `MSRA_ZERO16;
   assign wrValue = viewQ[1] ? (reqDataBit ? `MSRA_ONE16 : `MSRA_ZERO16) : reqData;
   wire logic [15:0] curWord = regQ[ptrQ];
   wire logic [15:0] rdWord = viewQ[1] ? ((curWord != `MSRA_ZERO16) ? `MSRA_ONE16 :
                                          `MSRA_ZERO16) : curWord;

   assign reqReady = idle && onQ;
   assign wrReady = inXfer && writeQ;

   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         MSRA_ST_IDLE: begin
            if (reqFire) begin
               stateD = reqBad ? MSRA_ST_DONE : MSRA_ST_XFER;
            end
         end
         MSRA_ST_XFER: begin
            if (stepOk && lastStep) begin
               stateD = MSRA_ST_DONE;
            end
         end
         MSRA_ST_DONE: begin
            stateD = MSRA_ST_IDLE;
         end
         default: begin
            stateD = MSRA_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         stateQ <= MSRA_ST_IDLE;
         ptrQ <= '0;
         leftQ <= '0;
         viewQ <= MSRA_VIEW_HOLD;
         writeQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         if (reqFire) begin
            ptrQ <= reqAddr;
            leftQ <= reqCount;
            viewQ <= reqView;
            writeQ <= reqWrite;
         end else if (stepOk) begin
            ptrQ <= ptrQ + (`MSRA_AW)'(1);
            leftQ <= leftQ - (`MSRA_AW+1)'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // response
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         validQ <= 1'b0;
         dataQ <= `MSRA_ZERO16;
         lastQ <= 1'b0;
         excQ <= 1'b0;
         excCodeQ <= `MSRA_EXC_NONE;
      end else begin
         validQ <= (reqFire && reqBad) || rdStep || (wrFire && lastStep);
         dataQ <= rdStep ? rdWord : `MSRA_ZERO16;
         lastQ <= (reqFire && reqBad) || (stepOk && lastStep);
         excQ <= reqFire && reqBad;
         excCodeQ <= (reqFire && reqBad) ? excCode : `MSRA_EXC_NONE;
      end
   end
   assign rspValid = validQ;
   assign rspData = dataQ;
   assign rspLast = lastQ;
   assign rspExc = excQ;
   assign rspExcCode = excCodeQ;

   // ------------------------------------------------------------
   // listening port, taken only at restart
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         portQ <= `MSRA_PORT_OFF;
         onQ <= 1'b0;
      end else if (restartReq) begin
         portQ <= cfgPort;
         onQ <= cfgPort != `MSRA_PORT_OFF;
      end
   end
   assign serverOn = onQ;
   assign listenPort = portQ;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_badReq;
      reqFire && reqBad;
   endsequence
   sequence s_excOut;
      rspValid && rspExc && rspLast;
   endsequence
   chk_exc_answer: assert property (@(posedge mclk) disable iff (!reset_n)
      s_badReq |=> s_excOut)
      else $error("bad request not answered by exception");
   chk_input_write: assert property (@(posedge mclk) disable iff (!reset_n)
      reqFire && reqWrite && reqView == MSRA_VIEW_INPUT |=> rspExc)
      else $error("input view write not refused");
   chk_bit_wide: assert property (@(posedge mclk) disable iff (!reset_n)
      reqFire && reqView[1] && isWide[reqAddr] |=> rspExc)
      else $error("bit access to wide register allowed");
   chk_bit_value: assert property (@(posedge mclk) disable iff (!reset_n)
      rdStep && viewQ[1] |=> rspData == ($past(curWord) != 16'h0000 ? 16'h0001 : 16'h0000))
      else $error("bit read value wrong");
   chk_hold_value: assert property (@(posedge mclk) disable iff (!reset_n)
      rdStep && !viewQ[1] |=> rspData == $past(curWord))
      else $error("holding word altered");
   chk_hold_write: assert property (@(posedge mclk) disable iff (!reset_n)
      wrFire && !viewQ[1] |=> regQ[$past(ptrQ)] == $past(reqData))
      else $error("holding write lost");
   chk_port_off: assert property (@(posedge mclk) disable iff (!reset_n)
      restartReq && cfgPort == 16'h0000 |=> !serverOn && !reqReady)
      else $error("server alive on port zero");
endmodule : msra_server

// ===== design/msra_params.svh
// constants for the modbus server register access block
`ifndef MSRA_PARAMS_SVH
`define MSRA_PARAMS_SVH
`define MSRA_NREGS 16
`define MSRA_AW 4
`define MSRA_REG_RESET 16'h0000
`define MSRA_FMT_RESET 2'h0
`define MSRA_PORT_STD 16'h01F6
`define MSRA_PORT_OFF 16'h0000
`define MSRA_ONE16 16'h0001
`define MSRA_ZERO16 16'h0000
`define MSRA_EXC_NONE 8'h00
`define MSRA_EXC_FUNC 8'h01
`define MSRA_EXC_ADDR 8'h02
`define MSRA_EXC_VALUE 8'h03
`endif

// ===== design/msra_pkg.sv
// types for the modbus server register access block
package msra_pkg;
   typedef enum logic [1:0] {
      MSRA_FMT_U16 = 2'b00,
      MSRA_FMT_S16 = 2'b01,
      MSRA_FMT_F32 = 2'b10,
      MSRA_FMT_STR = 2'b11
   } msra_fmt_t;
   typedef enum logic [1:0] {
      MSRA_VIEW_HOLD = 2'b00,
      MSRA_VIEW_INPUT = 2'b01,
      MSRA_VIEW_COIL = 2'b10,
      MSRA_VIEW_DISC = 2'b11
   } msra_view_t;
endpackage : msra_pkg

// ===== design/msra_check.sv
// access legality check for one request against the format table
`include "msra_params.svh"
module msra_check
   import msra_pkg::*;
(
   input wire logic [1:0] view,
   input wire logic isWrite,
   input wire logic [`MSRA_AW-1:0] addr,
   input wire logic [`MSRA_AW:0] count,
   input wire logic [`MSRA_NREGS-1:0] isStart,
   input wire logic [`MSRA_NREGS-1:0] isWide,
   output logic [7:0] excCode
);
   // ------------------------------------------------------------
   // legality terms
   // ------------------------------------------------------------
   wire logic [`MSRA_AW+1:0] endAddr = {1'b0, addr} + {1'b0, count};
   wire logic outOfRange = (count == '0) || (endAddr > (`MSRA_AW+2)'(`MSRA_NREGS));
   // a multi-bit request must not sweep over a wide value anywhere in its span
   logic [`MSRA_NREGS-1:0] covered;
   genvar gi;
   generate
      for (gi = 0; gi < `MSRA_NREGS; gi++) begin : g_cover
         assign covered[gi] = ((`MSRA_AW+2)'(gi) >= {2'b00, addr}) &&
                              ((`MSRA_AW+2)'(gi) < endAddr);
      end
   endgenerate
   wire logic inputWrite = isWrite && (view == MSRA_VIEW_INPUT) || isWrite && (view == MSRA_VIEW_DISC);
   wire logic bitOnWide = (view[1] == 1'b1) && (|(covered & isWide));
   wire logic midValue = !isStart[addr];
   // the end must also land on a value boundary, otherwise a float is cut in half
   wire logic endIdx = (endAddr == (`MSRA_AW+2)'(`MSRA_NREGS));
   wire logic [`MSRA_AW-1:0] endLow = endAddr[`MSRA_AW-1:0];
   wire logic midEnd = !endIdx && !isStart[endLow] && (view[1] == 1'b0);
   assign excCode = inputWrite ? `MSRA_EXC_FUNC :
                    outOfRange ? `MSRA_EXC_ADDR :
                    (bitOnWide || midValue || midEnd) ? `MSRA_EXC_ADDR : `MSRA_EXC_NONE;
endmodule : msra_check

// ===== verification/msra_client.sv
// remote client model: issues whole requests and collects response beats
`include "msra_params.svh"
module msra_client (
   input wire logic mclk,
   input wire logic reqReady,
   input wire logic wrReady,
   input wire logic rspValid,
   input wire logic [15:0] rspData,
   input wire logic rspLast,
   input wire logic rspExc,
   input wire logic [7:0] rspExcCode,
   output logic reqValid,
   output logic [1:0] reqView,
   output logic reqWrite,
   output logic [`MSRA_AW-1:0] reqAddr,
   output logic [`MSRA_AW:0] reqCount,
   output logic [15:0] reqData,
   output logic wrValid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] words [16];
   logic [15:0] beats [$];
   logic [7:0] code;
   logic excSeen;
   logic done;
   initial begin
      reqValid = 1'b0;
      reqView = 2'h0;
      reqWrite = 1'b0;
      reqAddr = '0;
      reqCount = '0;
      reqData = 16'h0000;
      wrValid = 1'b0;
      done = 1'b0;
   end
   always @(posedge mclk) begin
      if (rspValid) begin
         beats.push_back(rspData);
         code <= rspExcCode;
         excSeen <= rspExc;
         done <= rspLast;
      end
   end
   // one request per call, whole value or cut one (a cut value is refused by the server)
   task automatic run(input logic [1:0] v, input logic w, input logic [3:0] a,
                      input logic [4:0] n);
      int k;
      int t;
      beats.delete();
      done = 1'b0;
      t = 0;
      k = 0;
      @(posedge mclk);
      reqValid <= 1'b1;
      reqView <= v;
      reqWrite <= w;
      reqAddr <= a;
      reqCount <= n;
      do begin
         @(posedge mclk);
         t++;
      end while (!reqReady && t < 50);
      reqValid <= 1'b0;
      // the released address stops showing the old request
      reqAddr <= ~a;
      while (w && k < n && !done && t < 100) begin
         wrValid <= 1'b1;
         reqData <= words[k];
         @(posedge mclk);
         t++;
         if (wrReady) k++;
      end
      wrValid <= 1'b0;
      reqData <= ~reqData;
      while (!done && t < 100) begin
         @(posedge mclk);
         t++;
      end
      // one idle cycle before the next request
      @(posedge mclk);
   endtask : run
endmodule : msra_client

// ===== verification/testbench.sv
// self-checking bench for the modbus server register bank
`include "msra_params.svh"
module testbench
   import msra_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] v;
      logic w;
      logic [3:0] a;
      logic [4:0] n;
      logic [15:0] d;
      logic [7:0] c;
      logic [15:0] r;
   } msra_row_t;
   logic mclk, reset_n, restartReq, cfgWe, serverOn, reqReady, wrReady;
   logic rspValid, rspLast, rspExc, reqValid, reqWrite, wrValid;
   logic [15:0] cfgPort, listenPort, rspData, reqData;
   logic [1:0] cfgFmt, reqView;
   logic [`MSRA_AW-1:0] cfgAddr, reqAddr;
   logic [`MSRA_AW:0] reqCount;
   logic [7:0] rspExcCode;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   msra_row_t rows [17] = '{
      '{MSRA_VIEW_HOLD, 1'b1, 4'h1, 5'h01, 16'h0016, 8'h00, 16'h0000},
      '{MSRA_VIEW_INPUT, 1'b0, 4'h1, 5'h01, 16'h0000, 8'h00, 16'h0016},
      '{MSRA_VIEW_INPUT, 1'b1, 4'h1, 5'h01, 16'h1234, 8'h01, 16'h0000},
      '{MSRA_VIEW_DISC, 1'b0, 4'h1, 5'h01, 16'h0000, 8'h00, 16'h0001},
      '{MSRA_VIEW_DISC, 1'b0, 4'h0, 5'h01, 16'h0000, 8'h00, 16'h0000},
      '{MSRA_VIEW_COIL, 1'b0, 4'h5, 5'h01, 16'h0000, 8'h00, 16'h0001},
      '{MSRA_VIEW_COIL, 1'b1, 4'h0, 5'h01, 16'h0001, 8'h00, 16'h0000},
      '{MSRA_VIEW_HOLD, 1'b0, 4'h0, 5'h01, 16'h0000, 8'h00, 16'h0001},
      '{MSRA_VIEW_DISC, 1'b1, 4'h0, 5'h01, 16'h0001, 8'h01, 16'h0000},
      '{MSRA_VIEW_HOLD, 1'b0, 4'h9, 5'h01, 16'h0000, 8'h02, 16'h0000},
      '{MSRA_VIEW_HOLD, 1'b0, 4'h8, 5'h01, 16'h0000, 8'h02, 16'h0000},
      '{MSRA_VIEW_COIL, 1'b0, 4'h8, 5'h01, 16'h0000, 8'h02, 16'h0000},
      '{MSRA_VIEW_HOLD, 1'b0, 4'hD, 5'h01, 16'h0000, 8'h02, 16'h0000},
      '{MSRA_VIEW_HOLD, 1'b0, 4'hC, 5'h03, 16'h0000, 8'h00, 16'h0000},
      '{MSRA_VIEW_HOLD, 1'b0, 4'hF, 5'h02, 16'h0000, 8'h02, 16'h0000},
      '{MSRA_VIEW_COIL, 1'b1, 4'h2, 5'h01, 16'h0001, 8'h00, 16'h0000},
      '{MSRA_VIEW_DISC, 1'b0, 4'h2, 5'h01, 16'h0000, 8'h00, 16'h0001}
   };
   msra_server i_msra_server (
      .mclk(mclk), .reset_n(reset_n), .cfgPort(cfgPort), .restartReq(restartReq),
      .serverOn(serverOn), .listenPort(listenPort), .cfgWe(cfgWe), .cfgAddr(cfgAddr),
      .cfgFmt(cfgFmt), .reqValid(reqValid), .reqReady(reqReady), .reqView(reqView),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqCount(reqCount), .reqData(reqData),
      .wrValid(wrValid), .wrReady(wrReady), .rspValid(rspValid), .rspData(rspData),
      .rspLast(rspLast), .rspExc(rspExc), .rspExcCode(rspExcCode)
   );
   msra_client i_msra_client (
      .mclk(mclk), .reqReady(reqReady), .wrReady(wrReady), .rspValid(rspValid),
      .rspData(rspData), .rspLast(rspLast), .rspExc(rspExc), .rspExcCode(rspExcCode),
      .reqValid(reqValid), .reqView(reqView), .reqWrite(reqWrite), .reqAddr(reqAddr),
      .reqCount(reqCount), .reqData(reqData), .wrValid(wrValid)
   );
   // ----------------------------------------
   // checks and bus tasks
   // ----------------------------------------
   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {15'h0000, e}, {15'h0000, g});
   endtask : chk_bit
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   task automatic access(input msra_row_t x);
      i_msra_client.words[0] = x.d;
      i_msra_client.run(x.v, x.w, x.a, x.n);
      chk_bit("done", 1'b1, i_msra_client.done);
      chk_bit("exc", x.c != 8'h00, i_msra_client.excSeen);
      chk_word("code", {8'h00, x.c}, {8'h00, i_msra_client.code});
      chk_word("beat0", x.r, i_msra_client.beats[0]);
   endtask : access
   task automatic set_fmt(input logic [3:0] a, input logic [1:0] f);
      @(posedge mclk);
      cfgWe <= 1'b1;
      cfgAddr <= a;
      cfgFmt <= f;
      @(posedge mclk);
      cfgWe <= 1'b0;
   endtask : set_fmt
   task automatic restart(input logic [15:0] p);
      @(posedge mclk);
      restartReq <= 1'b1;
      cfgPort <= p;
      @(posedge mclk);
      restartReq <= 1'b0;
      @(posedge mclk);
   endtask : restart
   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   always #25 mclk = ~mclk;
   // the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      restartReq = 1'b0;
      cfgPort = 16'h0000;
      cfgWe = 1'b0;
      cfgAddr = 4'h0;
      cfgFmt = 2'h0;
      repeat (20) @(posedge mclk);
      chk_bit("reqReady", 1'b0, reqReady);
      chk_word("listenPort", `MSRA_PORT_OFF, listenPort);
      reset_n <= 1'b1;
      restart(`MSRA_PORT_STD);
      chk_bit("serverOn", 1'b1, serverOn);
      chk_word("listenPort", `MSRA_PORT_STD, listenPort);
      $display("reset and restart test done");
      set_fmt(4'h8, MSRA_FMT_F32);
      set_fmt(4'h9, MSRA_FMT_F32);
      for (int i = 12; i < 15; i++) set_fmt(i[3:0], MSRA_FMT_STR);
      set_fmt(4'h2, MSRA_FMT_S16);
      i_msra_client.words = '{0: 16'h007B, 1: 16'hFFFF, 2: 16'h0000, 3: 16'h11D7,
                              default: 16'h0000};
      i_msra_client.run(MSRA_VIEW_HOLD, 1'b1, 4'h4, 5'h04);
      chk_bit("done", 1'b1, i_msra_client.done);
      i_msra_client.run(MSRA_VIEW_HOLD, 1'b0, 4'h4, 5'h04);
      chk_bit("done", 1'b1, i_msra_client.done);
      for (int i = 0; i < 4; i++) begin
         chk_word("holdRead", i_msra_client.words[i], i_msra_client.beats[i]);
      end
      i_msra_client.words[0] = 16'h3F9D;
      i_msra_client.words[1] = 16'h70A4;
      i_msra_client.run(MSRA_VIEW_HOLD, 1'b1, 4'h8, 5'h02);
      chk_bit("done", 1'b1, i_msra_client.done);
      i_msra_client.run(MSRA_VIEW_HOLD, 1'b0, 4'h8, 5'h02);
      chk_bit("done", 1'b1, i_msra_client.done);
      chk_word("floatHi", 16'h3F9D, i_msra_client.beats[0]);
      chk_word("floatLo", 16'h70A4, i_msra_client.beats[1]);
      $display("multi word test done");
      foreach (rows[i]) access(rows[i]);
      $display("access table test done");
      // mid-run reset: server drops off, data and formats go back to their reset state
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      chk_bit("serverOn", 1'b0, serverOn);
      chk_word("listenPort", `MSRA_PORT_OFF, listenPort);
      reset_n <= 1'b1;
      restart(`MSRA_PORT_STD);
      access(msra_row_t'{MSRA_VIEW_HOLD, 1'b0, 4'h4, 5'h01, 16'h0000, 8'h00, 16'h0000});
      access(msra_row_t'{MSRA_VIEW_HOLD, 1'b0, 4'h9, 5'h01, 16'h0000, 8'h00, 16'h0000});
      $display("mid-run reset test done");
      restart(`MSRA_PORT_OFF);
      chk_bit("serverOn", 1'b0, serverOn);
      chk_bit("reqReady", 1'b0, reqReady);
      $display("server disable test done");
      stop_test();
   end
endmodule : testbench
